// File: logic/dsrc_core.sv
// Purpose: serial command interpreter for a single-channel digipot
// Assumes: sclk, sync_n, din, hw_reset are asynchronous pins, sclk well below clk_sys/8
// Notes:   fuse programming is immediate; no busy timing is modelled
`include "dsrc_regs.svh"

module dsrc_core (
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  input  wire logic                       sclk,
  input  wire logic                       sync_n,
  input  wire logic                       din,
  input  wire logic                       hw_reset,
  output logic                            sdo_o,
  output logic                            sdo_oe,
  output logic [`DSRC_CODE_BITS-1:0]      wiper_code_register,
  output dsrc_pkg::dsrc_ctrl_s            ctrl,
  output dsrc_pkg::dsrc_analog_s          analog,
  output logic                            shutdown,
  output logic [4:0]                      fuse_count,
  output logic [`DSRC_TAPS-1:0]           tap_sel
);
  import dsrc_pkg::*;

  // pin synchronisers, two flops each
  logic [1:0] sclk_s;
  logic [1:0] sync_s;
  logic [1:0] din_s;
  logic [1:0] hwr_s;
  logic       sclk_d;
  logic       sync_d;
  logic       hwr_d;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclk_s <= 2'h0;
      sync_s <= 2'h3;
      din_s  <= 2'h0;
      hwr_s  <= 2'h0;
    end else begin
      sclk_s <= {sclk_s[0], sclk};
      sync_s <= {sync_s[0], sync_n};
      din_s  <= {din_s[0], din};
      hwr_s  <= {hwr_s[0], hw_reset};
    end
  end

  // delayed copies for edge detection
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d <= 1'b0;
      sync_d <= 1'b1;
      hwr_d  <= 1'b0;
    end else begin
      sclk_d <= sclk_s[1];
      sync_d <= sync_s[1];
      hwr_d  <= hwr_s[1];
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic frame_start;
  logic frame_end;
  logic hwr_rise;

  // edges seen on the sampled pins
  assign sclk_rise   = sclk_s[1] & ~sclk_d;
  assign sclk_fall   = ~sclk_s[1] & sclk_d;
  assign frame_start = ~sync_s[1] & sync_d;
  assign frame_end   = sync_s[1] & ~sync_d;
  assign hwr_rise    = hwr_s[1] & ~hwr_d;

  // frame state and bit counter
  dsrc_frame_e frame;
  logic [5:0]  bit_cnt;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      frame   <= DSRC_IDLE;
      bit_cnt <= 6'h00;
    end else begin
      case (frame)
        DSRC_IDLE: begin
          if (frame_start) begin
            frame   <= DSRC_SHIFT;
            bit_cnt <= 6'h00;
          end
        end
        DSRC_SHIFT: begin
          if (frame_end) begin
            frame <= DSRC_IDLE;
          end else if (sclk_fall) begin
            bit_cnt <= bit_cnt + 6'h01;
          end
        end
        default: frame <= DSRC_IDLE;
      endcase
    end
  end

  logic                       shifting;
  logic                       execute;
  logic [`DSRC_WORD_BITS-1:0] sreg;
  dsrc_word_s                 word;

  // a frame executes only on a whole number of 16-bit words
  assign shifting = (frame == DSRC_SHIFT);
  assign execute  = shifting & frame_end & (bit_cnt != 6'h00) & (bit_cnt[3:0] == 4'h0);
  assign word     = sreg;

  // fuse memory and programmed count
  logic [`DSRC_CODE_BITS-1:0] fuse_mem [0:19];
  logic [`DSRC_CODE_BITS-1:0] stat_lo;
  logic [`DSRC_CODE_BITS-1:0] stat_hi;
  logic [`DSRC_CODE_BITS-1:0] reload_code;
  logic [`DSRC_CODE_BITS-1:0] fuse_rd;
  logic                       cmd_ok;
  logic                       do_store;

  // thermometer status words, one bit per programmed location
  genvar gi;
  generate
    for (gi = 0; gi < `DSRC_STAT_SPAN; gi = gi + 1) begin : g_stat
      assign stat_lo[gi] = (fuse_count > 5'(gi));
      assign stat_hi[gi] = (fuse_count > 5'(gi + `DSRC_STAT_SPAN));
    end
  endgenerate

  // reload value: last programmed location or midscale
  assign reload_code = (fuse_count == 5'h00) ? `DSRC_MIDSCALE
                       : fuse_mem[5'(fuse_count - 5'h01)];

  // fuse read mux on the five low data bits
  always_comb begin
    if (word.data[4:0] < `DSRC_FUSE_DEPTH) begin
      fuse_rd = fuse_mem[word.data[4:0]];
    end else if (word.data[4:0] == `DSRC_STAT_LO_ADDR) begin
      fuse_rd = stat_lo;
    end else if (word.data[4:0] == `DSRC_STAT_HI_ADDR) begin
      fuse_rd = stat_hi;
    end else begin
      fuse_rd = '0;
    end
  end

  assign cmd_ok   = execute & (word.top == `DSRC_TOP_ZERO);
  assign do_store = cmd_ok & (word.cmd == `DSRC_CMD_STORE) & ctrl.fuse_en
                    & (fuse_count < `DSRC_FUSE_DEPTH);

  // fuse array write, one location per store command
  always_ff @(posedge clk_sys) begin
    if (do_store) begin
      fuse_mem[fuse_count] <= wiper_code_register;
    end
  end

  // programmed count, blank part after power-up reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fuse_count <= 5'h00;
    end else if (do_store) begin
      fuse_count <= fuse_count + 5'h01;
    end
  end

  // power-on preset request, one cycle after reset release
  logic por_load;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      por_load <= 1'b1;
    end else begin
      por_load <= 1'b0;
    end
  end

  logic any_reset;

  assign any_reset = por_load | hwr_rise
                     | (cmd_ok & (word.cmd == `DSRC_CMD_SW_RESET));

  // wiper code register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wiper_code_register <= `DSRC_MIDSCALE;
    end else if (any_reset) begin
      wiper_code_register <= reload_code;
    end else if (cmd_ok & (word.cmd == `DSRC_CMD_WR_WIPER) & ctrl.guard) begin
      wiper_code_register <= word.data;
    end
  end

  // control register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `DSRC_CTRL_RST;
    end else if (any_reset) begin
      ctrl <= `DSRC_CTRL_RST;
    end else if (cmd_ok & (word.cmd == `DSRC_CMD_WR_CTRL)) begin
      ctrl.fuse_en <= word.data[0];
      ctrl.guard   <= word.data[1];
      ctrl.calib   <= word.data[2];
    end else if (do_store) begin
      ctrl.fuse_ok <= 1'b1;
    end
  end

  // shutdown flag, wiper code untouched
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shutdown <= 1'b0;
    end else if (any_reset) begin
      shutdown <= 1'b0;
    end else if (cmd_ok & (word.cmd == `DSRC_CMD_SHUTDOWN)) begin
      shutdown <= word.data[0];
    end
  end

  // analogue steering
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      analog <= '0;
    end else begin
      analog.term_a_open <= shutdown;
      analog.wiper_to_b  <= shutdown;
      analog.perf_mode   <= ~ctrl.calib;
    end
  end

  // shift register: din in on falling edge, readback loaded at frame end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sreg <= '0;
    end else if (cmd_ok & (word.cmd == `DSRC_CMD_RD_WIPER)) begin
      sreg <= {6'h00, wiper_code_register};
    end else if (cmd_ok & (word.cmd == `DSRC_CMD_RD_FUSE)) begin
      sreg <= {6'h00, fuse_rd};
    end else if (cmd_ok & (word.cmd == `DSRC_CMD_RD_CTRL)) begin
      sreg <= {12'h000, ctrl};
    end else if (shifting & sclk_fall) begin
      sreg <= {sreg[`DSRC_WORD_BITS-2:0], din_s[1]};
    end
  end

  // high impedance arming after the special word, set by the next no-op
  logic hiz_armed;
  logic hiz;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hiz_armed <= 1'b0;
      hiz       <= 1'b0;
    end else if (execute) begin
      if (word == `DSRC_HIZ_WORD) begin
        hiz_armed <= 1'b1;
      end else if (cmd_ok & (word.cmd == `DSRC_CMD_NOP)) begin
        hiz       <= hiz | hiz_armed;
        hiz_armed <= 1'b0;
      end else begin
        hiz       <= 1'b0;
        hiz_armed <= 1'b0;
      end
    end
  end

  // output bit: msb at frame start, then on every rising sclk
  logic next_sdo_bit;
  logic sdo_bit;

  always_comb begin
    next_sdo_bit = sdo_bit;
    if (frame_start) begin
      next_sdo_bit = sreg[`DSRC_WORD_BITS-1];
    end else if (shifting & sclk_rise) begin
      next_sdo_bit = sreg[`DSRC_WORD_BITS-1];
    end
  end

  // open-drain pin drive
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sdo_bit <= 1'b1;
      sdo_oe  <= 1'b0;
      sdo_o   <= 1'b0;
    end else begin
      sdo_bit <= next_sdo_bit;
      sdo_oe  <= ~next_sdo_bit & ~hiz;
      sdo_o   <= 1'b0;
    end
  end

  // tap decoder
  dsrc_tap_decode u_tap (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .code    (wiper_code_register),
    .tap_sel (tap_sel)
  );

endmodule

// File: logic/dsrc_regs.svh
// Purpose: named constants for the digipot serial readback control block
// Assumes: 10-bit wiper resolution, 16-bit serial word
// Notes:   included by every design file that needs a number
`ifndef DSRC_REGS_SVH
`define DSRC_REGS_SVH

// command codes in word bits 13:10
`define DSRC_CMD_NOP      4'h0
`define DSRC_CMD_WR_WIPER 4'h1
`define DSRC_CMD_RD_WIPER 4'h2
`define DSRC_CMD_STORE    4'h3
`define DSRC_CMD_SW_RESET 4'h4
`define DSRC_CMD_RD_FUSE  4'h5
`define DSRC_CMD_WR_CTRL  4'h6
`define DSRC_CMD_RD_CTRL  4'h7
`define DSRC_CMD_SHUTDOWN 4'h8

// word layout and special words
`define DSRC_WORD_BITS    16
`define DSRC_HIZ_WORD     16'h8001
`define DSRC_TOP_ZERO     2'h0

// wiper and fuse memory
`define DSRC_CODE_BITS    10
`define DSRC_TAPS         1024
`define DSRC_MIDSCALE     10'h200
`define DSRC_FUSE_DEPTH   5'h14
`define DSRC_STAT_LO_ADDR 5'h14
`define DSRC_STAT_HI_ADDR 5'h15
`define DSRC_STAT_SPAN    10

// control register reset value: fuse_en, guard, calib, fuse_ok all zero
`define DSRC_CTRL_RST     4'h0

`endif

// File: logic/dsrc_pkg.sv
// Purpose: shared types of the digipot serial readback control block
// Assumes: constants come from dsrc_regs.svh
// Notes:   control register bit order is C3..C0 from msb to lsb
package dsrc_pkg;

  // control register, C3 down to C0
  typedef struct packed {
    logic fuse_ok;   // C3, program success
    logic calib;     // C2, 0 = resistor performance mode
    logic guard;     // C1, 1 = wiper writes allowed
    logic fuse_en;   // C0, 1 = fuse program allowed
  } dsrc_ctrl_s;

  // one serial frame word
  typedef struct packed {
    logic [1:0] top;
    logic [3:0] cmd;
    logic [9:0] data;
  } dsrc_word_s;

  // analogue switch steering towards the resistor string
  typedef struct packed {
    logic term_a_open;
    logic wiper_to_b;
    logic perf_mode;
  } dsrc_analog_s;

  typedef enum logic [0:0] {
    DSRC_IDLE,
    DSRC_SHIFT
  } dsrc_frame_e;

endpackage

// File: logic/dsrc_tap_decode.sv
// Purpose: one-hot decode of the wiper code into tap selects
// Assumes: code comes from logic on the same clock
// Notes:   registered, so exactly one tap is live one cycle after a change
`include "dsrc_regs.svh"

module dsrc_tap_decode (
  input  wire logic                        clk_sys,
  input  wire logic                        rst_n,
  input  wire logic [`DSRC_CODE_BITS-1:0]  code,
  output logic      [`DSRC_TAPS-1:0]       tap_sel
);

  // one compare per tap
  genvar i;
  generate
    for (i = 0; i < `DSRC_TAPS; i = i + 1) begin : g_tap
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          tap_sel[i] <= 1'b0;
        end else begin
          tap_sel[i] <= (code == `DSRC_CODE_BITS'(i));
        end
      end
    end
  endgenerate

endmodule

// File: bench/dsrc_core_assertions.sv
// Purpose: port-level checks of the digipot serial command block
// Assumes: frames are spaced by the host model, hw_reset is never pulsed mid-frame
// Notes:   bound into dsrc_core at the foot of this file
`include "dsrc_regs.svh"

module dsrc_core_chk (
  input wire logic                        clk_sys,
  input wire logic                        rst_n,
  input wire logic                        sclk,
  input wire logic                        sync_n,
  input wire logic                        din,
  input wire logic                        hw_reset,
  input wire logic                        sdo_o,
  input wire logic                        sdo_oe,
  input wire logic [`DSRC_CODE_BITS-1:0]  wiper_code_register,
  input wire dsrc_pkg::dsrc_ctrl_s        ctrl,
  input wire dsrc_pkg::dsrc_analog_s      analog,
  input wire logic                        shutdown,
  input wire logic [4:0]                  fuse_count,
  input wire logic [`DSRC_TAPS-1:0]       tap_sel
);
  timeunit 1ns;
  timeprecision 100ps;
  import dsrc_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // output pin, tap decode and analogue steering
  AST_SDO_LOW_ONLY: assert property (sdo_o == 1'b0) else $error("sdo data not low");
  AST_TAP_ONEHOT: assert property ($past(rst_n, 2) |-> $onehot(tap_sel)) else $error("tap not one-hot");
  AST_TAP_FOLLOW: assert property ($past(rst_n, 2) |->
    tap_sel == (`DSRC_TAPS'(1) << $past(wiper_code_register))) else $error("tap not at wiper code");
  AST_SHDN_TERM: assert property ($past(rst_n) |-> analog.term_a_open == $past(shutdown)
    && analog.wiper_to_b == $past(shutdown)) else $error("terminals not following shutdown");
  AST_PERF_CALIB: assert property ($past(rst_n) |-> analog.perf_mode == !$past(ctrl.calib))
    else $error("perf mode not following calib bit");
  // hardware reset effects
  AST_HWRST_CLEAR: assert property ($rose(hw_reset) |-> ##[2:8] (ctrl == '0 && !shutdown))
    else $error("control not cleared by reset pin");
  AST_HWRST_MID: assert property ($rose(hw_reset) && fuse_count == 5'h0 |->
    ##[2:8] wiper_code_register == `DSRC_MIDSCALE) else $error("blank reload not midscale");
  // state only moves once a frame has closed
  AST_FRAME_HOLD: assert property ((!sync_n)[*8] |-> $stable(wiper_code_register)
    && $stable(ctrl) && $stable(shutdown)) else $error("state changed inside frame");
  AST_FUSE_STEP: assert property (fuse_count == $past(fuse_count)
    || fuse_count == $past(fuse_count) + 5'h1) else $error("fuse count jumped");

  COV_SHDN: cover property ($rose(shutdown));
  COV_FUSE: cover property (fuse_count == 5'h1);
  COV_HWRST: cover property ($rose(hw_reset));
endmodule

bind dsrc_core dsrc_core_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .sync_n(sync_n), .din(din),
  .hw_reset(hw_reset), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .wiper_code_register(wiper_code_register),
  .ctrl(ctrl), .analog(analog), .shutdown(shutdown), .fuse_count(fuse_count), .tap_sel(tap_sel));

// File: bench/dsrc_host_model.sv
// Purpose: host serial controller driving frames into the block
// Assumes: sclk idles high, 64 ns period, din taken by the block on sclk fall
// Notes:   one frame per rise of go, done stays high until the next go
module dsrc_host_model (
  input  wire logic        go,
  input  wire logic [31:0] tx,
  input  wire logic [5:0]  nbits,
  input  wire logic        sdo_line,
  output logic             sclk,
  output logic             sync_n,
  output logic             din,
  output logic [31:0]      rx,
  output logic             done
);
  timeunit 1ns;
  timeprecision 100ps;
  int i;

  // shift msb first, sample sdo at each fall; clock stands still between frames
  initial begin
    sclk = 1'b1;
    sync_n = 1'b1;
    din = 1'b0;
    rx = '0;
    done = 1'b0;
    forever begin
      @(posedge go);
      done = 1'b0;
      #7 sync_n = 1'b0;
      for (i = int'(nbits) - 1; i >= 0; i--) begin
        din = tx[i];
        #32 sclk = 1'b0;
        rx = {rx[30:0], sdo_line};
        #32 sclk = 1'b1;
      end
      #32 sync_n = 1'b1;
      din = ~din;
      #40 done = 1'b1;
    end
  end
endmodule

// File: bench/testbench.sv
// Purpose: self-checking bench of the digipot serial command block
// Assumes: blank fuse memory at power-on, host model on the serial pins
// Notes:   sdo words checked from a queue of notes, state checked directly
`include "dsrc_regs.svh"

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import dsrc_pkg::*;
  typedef struct { logic [31:0] e; logic [31:0] m; } dsrc_note_s;
  logic                       clk_sys = 1'b0;
  logic                       rst_n = 1'b0;
  logic                       hw_reset = 1'b0;
  logic                       go = 1'b0;
  logic [31:0]                tx = '0;
  logic [5:0]                 nbits = 6'h10;
  logic                       sclk, sync_n, din, sdo_o, sdo_oe, shutdown, done;
  logic [31:0]                rx;
  logic [`DSRC_CODE_BITS-1:0] wiper, v, w;
  dsrc_ctrl_s                 ctrl;
  dsrc_analog_s               analog;
  logic [4:0]                 fuse_count;
  logic [`DSRC_TAPS-1:0]      tap_sel;
  logic [15:0]                seed = 16'h0008;
  int                         errors = 0;
  int                         samples_checked = 0;
  dsrc_note_s                 notes[$];
  wire                        sdo_line = sdo_oe ? sdo_o : 1'b1; // pull-up when released

  always #2.5 clk_sys = ~clk_sys;

  dsrc_core dut (.clk_sys(clk_sys), .rst_n(rst_n), .sclk(sclk), .sync_n(sync_n), .din(din), .hw_reset(hw_reset),
    .sdo_o(sdo_o), .sdo_oe(sdo_oe), .wiper_code_register(wiper), .ctrl(ctrl), .analog(analog),
    .shutdown(shutdown), .fuse_count(fuse_count), .tap_sel(tap_sel));
  dsrc_host_model host (.go(go), .tx(tx), .nbits(nbits), .sdo_line(sdo_line), .sclk(sclk), .sync_n(sync_n),
    .din(din), .rx(rx), .done(done));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // xorshift source for wiper codes
  function automatic logic [9:0] rnd();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed[9:0];
  endfunction

  // note the expected sdo word, then run one frame
  task automatic frame(input logic [31:0] t, input logic [5:0] n, input logic [31:0] e, input logic [31:0] m);
    int k;
    notes.push_back('{e, m});
    @(posedge clk_sys);
    tx <= t;
    nbits <= n;
    go <= 1'b1;
    k = 0;
    @(posedge clk_sys);
    while (done !== 1'b1 && k < 1000) begin
      @(posedge clk_sys);
      k++;
    end
    // a frame that never finishes counts as a mismatch
    if (done !== 1'b1) begin
      errors++;
    end
    go <= 1'b0;
    repeat (8) @(posedge clk_sys);
  endtask

  task automatic f16(input logic [15:0] t, input logic [15:0] e, input logic m);
    frame({16'h0000, t}, 6'h10, {16'h0000, e}, m ? 32'h0000_FFFF : 32'h0000_0000);
  endtask

  task automatic pulse_hw();
    hw_reset <= 1'b1;
    repeat (4) @(posedge clk_sys);
    hw_reset <= 1'b0;
    repeat (10) @(posedge clk_sys);
  endtask

  // result watcher: oldest note against the word just shifted out
  always @(posedge done) begin
    dsrc_note_s nt;
    nt = notes.pop_front();
    chk("sdo word", nt.e & nt.m, rx & nt.m);
  end

  task automatic results();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // watchdog on the whole sequence
  initial begin
    repeat (40000) @(posedge clk_sys);
    errors++;
    results();
  end

  // main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    v = rnd();
    w = rnd();
    chk("wiper", 32'(`DSRC_MIDSCALE), 32'(wiper));
    chk("perf", 32'h1, 32'(analog.perf_mode));
    f16(16'h1C00, 16'h0000, 1'b1);
    f16(16'h1414, 16'h0000, 1'b1);
    f16(16'h1415, 16'h0000, 1'b1);
    f16(16'h0000, 16'h0000, 1'b1);
    f16({6'h01, v}, 16'h0000, 1'b1);
    chk("wiper", 32'(`DSRC_MIDSCALE), 32'(wiper));
    f16(16'h1802, {6'h01, v}, 1'b1);
    f16({6'h01, v}, 16'h1802, 1'b1);
    chk("wiper", 32'(v), 32'(wiper));
    pulse_hw();
    chk("wiper", 32'(`DSRC_MIDSCALE), 32'(wiper));
    f16(16'h1803, {6'h01, v}, 1'b1);
    f16({6'h01, w}, 16'h1803, 1'b1);
    f16(16'h0800, {6'h01, w}, 1'b1);
    f16(16'h2001, {6'h00, w}, 1'b1);
    chk("shutdown", 32'h1, 32'(shutdown));
    chk("analog", 32'h7, 32'(analog));
    f16(16'h0C00, 16'h2001, 1'b1);
    chk("wiper", 32'(w), 32'(wiper));
    chk("fuses", 32'h1, 32'(fuse_count));
    f16(16'h2000, 16'h0C00, 1'b1);
    chk("analog", 32'h1, 32'(analog));
    f16(16'h17E0, 16'h2000, 1'b1);
    f16(16'h1414, {6'h00, w}, 1'b1);
    f16(16'h1415, 16'h0001, 1'b1);
    f16({6'h01, ~w}, 16'h0000, 1'b1);
    f16(16'h1000, {6'h01, ~w}, 1'b1);
    chk("wiper", 32'(w), 32'(wiper));
    chk("ctrl", 32'h0, 32'(ctrl));
    f16(16'h1802, 16'h1000, 1'b1);
    f16({6'h01, ~w}, 16'h1802, 1'b1);
    pulse_hw();
    chk("wiper", 32'(w), 32'(wiper));
    f16(16'h1804, {6'h01, ~w}, 1'b1);
    chk("perf", 32'h0, 32'(analog.perf_mode));
    f16(16'h8001, 16'h1804, 1'b1);
    f16(16'h0000, 16'h8001, 1'b1);
    f16(16'h0800, 16'hFFFF, 1'b1);
    frame({16'h1C00, 16'h0800}, 6'h20, {6'h00, w, 16'h1C00}, 32'hFFFF_FFFF);
    f16(16'h0000, {6'h00, w}, 1'b1);
    results();
  end
endmodule
